// File: rtl/rxmp_pkg.sv
package rxmp_pkg;
  localparam int RXMP_ADDR_W = 12;
  localparam int RXMP_MODES = 5;
  localparam int RXMP_REGS_PER_MODE = 3;
  localparam int RXMP_REG_COUNT = 15;
  localparam logic [3:0] RXMP_FIRST_MODE = 4'ha;
  // register addresses, three per mode in enable / gain12 / gain34 order
  localparam logic [11:0] RXMP_REG_ADDR [0:14] = '{
    12'h05e, 12'h05f, 12'h060, 12'h061, 12'h062, 12'h063, 12'h064, 12'h065,
    12'h066, 12'h067, 12'h068, 12'h069, 12'h06a, 12'h06b, 12'h06c};
  // slot positions within one mode
  localparam int RXMP_SLOT_EN = 0;
  localparam int RXMP_SLOT_G12 = 1;
  localparam int RXMP_SLOT_G34 = 2;
  // field positions
  localparam int RXMP_FIRST_SPLIT_BIT = 6;
  localparam int RXMP_PAIR_A_SPLIT_BIT = 5;
  localparam int RXMP_PAIR_B_SPLIT_BIT = 4;
  localparam int RXMP_CHAN_ON_MSB = 3;
  localparam int RXMP_GAIN_HI_LSB = 4;
  localparam int RXMP_GAIN_LO_LSB = 0;
  localparam int RXMP_GAIN_W = 3;
  // writable bits; everything else is reserved and reads zero
  localparam logic [7:0] RXMP_EN_MASK = 8'h7f;
  localparam logic [7:0] RXMP_GAIN_MASK = 8'h77;
  // reset values per mode, index 0 is mode 10
  localparam logic [7:0] RXMP_EN_RST [0:4] = '{
    8'h7f, 8'h68, 8'h64, 8'h52, 8'h51};
  localparam logic [7:0] RXMP_G12_RST [0:4] = '{
    8'h44, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RXMP_G34_RST [0:4] = '{
    8'h44, 8'h00, 8'h00, 8'h00, 8'h00};
endpackage

// File: rtl/rxmp_mode_slot.sv
`timescale 1ns/1ns
module rxmp_mode_slot
  import rxmp_pkg::*;
#(
  parameter logic [7:0] EN_RST = 8'h00,
  parameter logic [7:0] G12_RST = 8'h00,
  parameter logic [7:0] G34_RST = 8'h00
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] wrSel,
  input wire logic [7:0] wrData,
  output logic [7:0] enByte,
  output logic [7:0] gain12Byte,
  output logic [7:0] gain34Byte
);
  localparam logic [7:0] RST_VAL [0:2] = '{EN_RST, G12_RST, G34_RST};
  localparam logic [7:0] MASK [0:2] = '{RXMP_EN_MASK, RXMP_GAIN_MASK, RXMP_GAIN_MASK};

  logic [7:0] slotByte_reg [0:2];

  // one byte per register; reserved bits never take a write
  for (genvar k = 0; k < RXMP_REGS_PER_MODE; k++) begin : g_byte
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        slotByte_reg[k] <= RST_VAL[k] & MASK[k];
      end else if (wrSel[k]) begin
        slotByte_reg[k] <= wrData & MASK[k];
      end
    end
  end

  assign enByte = slotByte_reg[RXMP_SLOT_EN];
  assign gain12Byte = slotByte_reg[RXMP_SLOT_G12];
  assign gain34Byte = slotByte_reg[RXMP_SLOT_G34];
endmodule

// File: rtl/rxmp_profile_drive.sv
`timescale 1ns/1ns
module rxmp_profile_drive
  import rxmp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic selValid,
  input wire logic [7:0] selEn,
  input wire logic [7:0] selGain12,
  input wire logic [7:0] selGain34,
  output logic profileActive,
  output logic firstSplitterOn,
  output logic pairASplitterOn,
  output logic pairBSplitterOn,
  output logic [3:0] chanOn,
  output logic [2:0] chan1GainCode,
  output logic [2:0] chan2GainCode,
  output logic [2:0] chan3GainCode,
  output logic [2:0] chan4GainCode
);
  logic active_reg;
  logic [7:0] en_reg;
  logic [7:0] g12_reg;
  logic [7:0] g34_reg;

  // registered so the front end never sees decode glitches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_reg <= 1'b0;
      en_reg <= 8'h00;
      g12_reg <= 8'h00;
      g34_reg <= 8'h00;
    end else begin
      active_reg <= selValid;
      en_reg <= selEn;
      g12_reg <= selGain12;
      g34_reg <= selGain34;
    end
  end

  // field split of the held profile
  assign profileActive = active_reg;
  assign firstSplitterOn = en_reg[RXMP_FIRST_SPLIT_BIT];
  assign pairASplitterOn = en_reg[RXMP_PAIR_A_SPLIT_BIT];
  assign pairBSplitterOn = en_reg[RXMP_PAIR_B_SPLIT_BIT];
  assign chanOn = {en_reg[RXMP_CHAN_ON_MSB - 3], en_reg[RXMP_CHAN_ON_MSB - 2],
                   en_reg[RXMP_CHAN_ON_MSB - 1], en_reg[RXMP_CHAN_ON_MSB]};
  assign chan1GainCode = g12_reg[RXMP_GAIN_HI_LSB +: RXMP_GAIN_W];
  assign chan2GainCode = g12_reg[RXMP_GAIN_LO_LSB +: RXMP_GAIN_W];
  assign chan3GainCode = g34_reg[RXMP_GAIN_HI_LSB +: RXMP_GAIN_W];
  assign chan4GainCode = g34_reg[RXMP_GAIN_LO_LSB +: RXMP_GAIN_W];
endmodule

// File: rtl/rxmp_regs.sv
`timescale 1ns/1ns
module rxmp_regs
  import rxmp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [RXMP_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regHit,
  input wire logic [3:0] modeSel,
  output logic profileActive,
  output logic firstSplitterOn,
  output logic pairASplitterOn,
  output logic pairBSplitterOn,
  output logic [3:0] chanOn,
  output logic [2:0] chan1GainCode,
  output logic [2:0] chan2GainCode,
  output logic [2:0] chan3GainCode,
  output logic [2:0] chan4GainCode
);
  logic [RXMP_REG_COUNT-1:0] addrMatch;
  logic [RXMP_REG_COUNT-1:0] wrStrobe;
  logic [7:0] slotByte [0:RXMP_REG_COUNT-1];
  logic [7:0] rdAcc [0:RXMP_REG_COUNT];
  logic [RXMP_MODES-1:0] modeMatch;
  logic [7:0] enAcc [0:RXMP_MODES];
  logic [7:0] g12Acc [0:RXMP_MODES];
  logic [7:0] g34Acc [0:RXMP_MODES];
  logic [7:0] regRdData_reg;
  logic anyWrite_reg;

  // address decode, one comparator per register
  for (genvar i = 0; i < RXMP_REG_COUNT; i++) begin : g_dec
    assign addrMatch[i] = (regAddr == RXMP_REG_ADDR[i]);
    assign wrStrobe[i] = regWrEn && addrMatch[i];
    assign rdAcc[i + 1] = rdAcc[i] | ({8{addrMatch[i]}} & slotByte[i]);
  end
  assign rdAcc[0] = 8'h00;
  assign regHit = |addrMatch;

  // storage, three bytes per receiver mode
  for (genvar m = 0; m < RXMP_MODES; m++) begin : g_mode
    rxmp_mode_slot #(
      .EN_RST(RXMP_EN_RST[m]),
      .G12_RST(RXMP_G12_RST[m]),
      .G34_RST(RXMP_G34_RST[m])
    ) u_slot (
      .clk(clk),
      .rst_b(rst_b),
      .wrSel(wrStrobe[RXMP_REGS_PER_MODE * m +: RXMP_REGS_PER_MODE]),
      .wrData(regWrData),
      .enByte(slotByte[RXMP_REGS_PER_MODE * m + RXMP_SLOT_EN]),
      .gain12Byte(slotByte[RXMP_REGS_PER_MODE * m + RXMP_SLOT_G12]),
      .gain34Byte(slotByte[RXMP_REGS_PER_MODE * m + RXMP_SLOT_G34])
    );
    // mode select, and-or so a missing match gives an all-off profile
    assign modeMatch[m] = (modeSel == 4'(RXMP_FIRST_MODE + m));
    assign enAcc[m + 1] = enAcc[m] |
      ({8{modeMatch[m]}} & slotByte[RXMP_REGS_PER_MODE * m + RXMP_SLOT_EN]);
    assign g12Acc[m + 1] = g12Acc[m] |
      ({8{modeMatch[m]}} & slotByte[RXMP_REGS_PER_MODE * m + RXMP_SLOT_G12]);
    assign g34Acc[m + 1] = g34Acc[m] |
      ({8{modeMatch[m]}} & slotByte[RXMP_REGS_PER_MODE * m + RXMP_SLOT_G34]);
  end
  assign enAcc[0] = 8'h00;
  assign g12Acc[0] = 8'h00;
  assign g34Acc[0] = 8'h00;

  // read data held until the next read; unmapped addresses answer zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData_reg <= 8'h00;
    end else if (regRdEn) begin
      regRdData_reg <= rdAcc[RXMP_REG_COUNT];
    end
  end
  assign regRdData = regRdData_reg;

  // output stage registers the selected profile
  rxmp_profile_drive u_drive (
    .clk(clk),
    .rst_b(rst_b),
    .selValid(|modeMatch),
    .selEn(enAcc[RXMP_MODES]),
    .selGain12(g12Acc[RXMP_MODES]),
    .selGain34(g34Acc[RXMP_MODES]),
    .profileActive(profileActive),
    .firstSplitterOn(firstSplitterOn),
    .pairASplitterOn(pairASplitterOn),
    .pairBSplitterOn(pairBSplitterOn),
    .chanOn(chanOn),
    .chan1GainCode(chan1GainCode),
    .chan2GainCode(chan2GainCode),
    .chan3GainCode(chan3GainCode),
    .chan4GainCode(chan4GainCode)
  );

  // named views of a few stored fields, read by the checks below
  logic mode10FirstSplitterOn;
  logic [3:0] mode10ChanOn;
  logic [2:0] mode10Chan1GainCode;
  logic [2:0] mode10Chan3GainCode;
  logic mode11FirstSplitterOn;
  logic mode11PairASplitterOn;
  logic mode11PairBSplitterOn;
  logic mode11Chan1On;
  logic [2:0] mode11Chan3GainCode;
  logic mode12Chan2On;
  logic [2:0] mode12Chan1GainCode;
  logic [2:0] mode12Chan3GainCode;
  logic mode13Chan3On;
  logic [2:0] mode13Chan4GainCode;
  logic mode14Chan4On;
  assign mode10FirstSplitterOn = slotByte[0][RXMP_FIRST_SPLIT_BIT];
  assign mode10ChanOn = slotByte[0][RXMP_CHAN_ON_MSB:0];
  assign mode10Chan1GainCode = slotByte[1][RXMP_GAIN_HI_LSB +: RXMP_GAIN_W];
  assign mode10Chan3GainCode = slotByte[2][RXMP_GAIN_HI_LSB +: RXMP_GAIN_W];
  assign mode11FirstSplitterOn = slotByte[3][RXMP_FIRST_SPLIT_BIT];
  assign mode11PairASplitterOn = slotByte[3][RXMP_PAIR_A_SPLIT_BIT];
  assign mode11PairBSplitterOn = slotByte[3][RXMP_PAIR_B_SPLIT_BIT];
  assign mode11Chan1On = slotByte[3][RXMP_CHAN_ON_MSB];
  assign mode11Chan3GainCode = slotByte[5][RXMP_GAIN_HI_LSB +: RXMP_GAIN_W];
  assign mode12Chan2On = slotByte[6][RXMP_CHAN_ON_MSB - 1];
  assign mode12Chan1GainCode = slotByte[7][RXMP_GAIN_HI_LSB +: RXMP_GAIN_W];
  assign mode12Chan3GainCode = slotByte[8][RXMP_GAIN_HI_LSB +: RXMP_GAIN_W];
  assign mode13Chan3On = slotByte[9][RXMP_CHAN_ON_MSB - 2];
  assign mode13Chan4GainCode = slotByte[11][RXMP_GAIN_LO_LSB +: RXMP_GAIN_W];
  assign mode14Chan4On = slotByte[12][0];

  // helper: low until the first register write after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      anyWrite_reg <= 1'b0;
    end else if (regWrEn) begin
      anyWrite_reg <= 1'b1;
    end
  end

  // reset profiles hold until software first writes
  a_mode10_chan_on: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (mode10ChanOn == 4'hf && mode10FirstSplitterOn))
    else $error("mode 10 channel enables not all on after reset");

  a_mode10_splitters: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (slotByte[0][6:4] == 3'h7))
    else $error("mode 10 splitter enables not all on after reset");

  a_mode10_gains: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (mode10Chan1GainCode == 3'h4 && slotByte[1][2:0] == 3'h4))
    else $error("mode 10 channel 1-2 gain reset wrong");

  a_mode10_gains34: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (mode10Chan3GainCode == 3'h4 && slotByte[2][2:0] == 3'h4))
    else $error("mode 10 channel 3-4 gain reset wrong");

  a_mode11_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (mode11FirstSplitterOn && mode11PairASplitterOn &&
      !mode11PairBSplitterOn && mode11Chan1On && slotByte[3][2:0] == 3'h0))
    else $error("mode 11 enable reset wrong");

  a_mode11_gains: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (slotByte[4] == 8'h00 && mode11Chan3GainCode == 3'h0 &&
      slotByte[5] == 8'h00))
    else $error("mode 11 gain reset not zero");

  a_mode12_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (slotByte[6][6:4] == 3'h6 && mode12Chan2On &&
      slotByte[6][3:0] == 4'h4))
    else $error("mode 12 enable reset wrong");

  a_mode12_gains: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (mode12Chan1GainCode == 3'h0 && mode12Chan3GainCode == 3'h0 &&
      (slotByte[7] | slotByte[8]) == 8'h00))
    else $error("mode 12 gain reset not zero");

  a_mode13_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (slotByte[9][6:4] == 3'h5 && mode13Chan3On &&
      slotByte[9][3:0] == 4'h2))
    else $error("mode 13 enable reset wrong");

  a_mode13_gains: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (mode13Chan4GainCode == 3'h0 &&
      (slotByte[10] | slotByte[11]) == 8'h00))
    else $error("mode 13 gain reset not zero");

  a_mode14_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    !anyWrite_reg |-> (slotByte[12][6:4] == 3'h5 && mode14Chan4On &&
      slotByte[12][3:0] == 4'h1))
    else $error("mode 14 enable reset wrong");

  // a write lands at its own address only, reserved bits dropped
  for (genvar i = 0; i < RXMP_REG_COUNT; i++) begin : g_chk
    a_write_lands: assert property (
      @(posedge clk) disable iff (!rst_b)
      wrStrobe[i] |=> slotByte[i] == ($past(regWrData) &
        ((i % RXMP_REGS_PER_MODE == RXMP_SLOT_EN) ? RXMP_EN_MASK : RXMP_GAIN_MASK)))
      else $error("register write did not land masked");
    a_reserved_zero: assert property (
      @(posedge clk) disable iff (!rst_b)
      (i % RXMP_REGS_PER_MODE == RXMP_SLOT_EN) ? !slotByte[i][7] :
        (slotByte[i][7] == 1'b0 && slotByte[i][3] == 1'b0))
      else $error("reserved bit reads one");
    a_other_kept: assert property (
      @(posedge clk) disable iff (!rst_b)
      !wrStrobe[i] |=> $stable(slotByte[i]))
      else $error("register changed without a write");
    a_read_mapped: assert property (
      @(posedge clk) disable iff (!rst_b)
      (regRdEn && addrMatch[i]) |=> regRdData == $past(slotByte[i]))
      else $error("mapped read returned the wrong byte");
  end

  // read returns the addressed byte one cycle later, zero when unmapped
  a_read_data: assert property (
    @(posedge clk) disable iff (!rst_b)
    (regRdEn && !regHit) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");

  a_read_held: assert property (
    @(posedge clk) disable iff (!rst_b)
    !regRdEn |=> $stable(regRdData))
    else $error("read data moved without a read");

  // selected profile reaches the front end one cycle after the selection;
  // bytes are those of the select edge, so a write there shows one cycle later
  a_profile_drive: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel == RXMP_FIRST_MODE + 4'h2) |=> (profileActive && chanOn ==
      {$past(slotByte[6][0]), $past(slotByte[6][1]), $past(slotByte[6][2]),
      $past(slotByte[6][3])} && chan1GainCode == $past(slotByte[7][6:4]) &&
      chan4GainCode == $past(slotByte[8][2:0])))
    else $error("mode 12 profile not driven");

  a_splitter_map: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel == RXMP_FIRST_MODE) |=> (profileActive && firstSplitterOn ==
      $past(slotByte[0][6]) && pairASplitterOn == $past(slotByte[0][5]) &&
      pairBSplitterOn == $past(slotByte[0][4])))
    else $error("splitter enables mis-mapped");

  a_off_range: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel < RXMP_FIRST_MODE) |=> (!profileActive && chanOn == 4'h0 &&
      !firstSplitterOn && chan2GainCode == 3'h0 && chan3GainCode == 3'h0))
    else $error("profile driven for unselected mode");

  a_off_high: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel > RXMP_FIRST_MODE + 4'h4) |=> (!profileActive && chanOn == 4'h0 &&
      !pairASplitterOn && !pairBSplitterOn && chan1GainCode == 3'h0 &&
      chan4GainCode == 3'h0))
    else $error("profile driven above mode 14");

  // upper modes must also raise the active flag
  a_active_range: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel >= RXMP_FIRST_MODE + 4'h3 && modeSel <= RXMP_FIRST_MODE + 4'h4) |=> profileActive)
    else $error("mode 13 or 14 profile not active");

  // gain fields: odd channel in the high nibble, even channel in the low one
  a_gain_map: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel == RXMP_FIRST_MODE) |=> (chan1GainCode == $past(slotByte[1][6:4]) &&
      chan2GainCode == $past(slotByte[1][2:0]) && chan3GainCode == $past(slotByte[2][6:4]) &&
      chan4GainCode == $past(slotByte[2][2:0])))
    else $error("gain codes mis-mapped");

  // channel 1 lives in the byte's bit 3 but leaves on chanOn bit 0
  a_chan_order: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel == RXMP_FIRST_MODE + 4'h1) |=> (chanOn == {$past(slotByte[3][0]),
      $past(slotByte[3][1]), $past(slotByte[3][2]), $past(slotByte[3][3])} &&
      firstSplitterOn == $past(slotByte[3][6])))
    else $error("mode 11 channel enables mis-mapped");

  a_mode13_drive: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel == RXMP_FIRST_MODE + 4'h3) |=> (chanOn == {$past(slotByte[9][0]),
      $past(slotByte[9][1]), $past(slotByte[9][2]), $past(slotByte[9][3])} &&
      pairBSplitterOn == $past(slotByte[9][4]) && chan1GainCode == $past(slotByte[10][6:4])))
    else $error("mode 13 profile not driven");

  a_mode14_drive: assert property (
    @(posedge clk) disable iff (!rst_b)
    (modeSel == RXMP_FIRST_MODE + 4'h4) |=> (chanOn == {$past(slotByte[12][0]),
      $past(slotByte[12][1]), $past(slotByte[12][2]), $past(slotByte[12][3])} &&
      chan3GainCode == $past(slotByte[14][6:4]) && chan2GainCode == $past(slotByte[13][2:0])))
    else $error("mode 14 profile not driven");

  // regHit covers exactly the fifteen mapped addresses
  a_hit_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    regHit == (regAddr >= RXMP_REG_ADDR[0] &&
      regAddr <= RXMP_REG_ADDR[RXMP_REG_COUNT - 1]))
    else $error("address hit decode wrong");

  // a decode overlap would let one write land in two registers
  a_one_strobe: assert property (
    @(posedge clk) disable iff (!rst_b)
    $onehot0(wrStrobe))
    else $error("write strobed more than one register");
endmodule

// File: tb/rxmp_host_model.sv
`timescale 1ns/1ns
// stands in for the serial port front end: one byte per strobe
module rxmp_host_model
  import rxmp_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] regRdData,
  output logic [RXMP_ADDR_W-1:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn
);
  // idle levels at time zero, strobes low
  initial begin
    regAddr = '0;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  // data is inverted after a write so a stale bus value never looks valid
  task automatic write_reg(input logic [RXMP_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #2;
    regWrEn = 1'b0;
    regWrData = ~d;
  endtask

  // read data is taken just after the edge that samples the strobe
  task automatic read_reg(input logic [RXMP_ADDR_W-1:0] a, output logic [7:0] q);
    @(posedge clk);
    #2;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    #2;
    regRdEn = 1'b0;
    q = regRdData;
  endtask

  // both strobes on one edge, the read must see the old byte
  task automatic write_read(input logic [RXMP_ADDR_W-1:0] a, input logic [7:0] d,
                            output logic [7:0] q);
    @(posedge clk);
    #2;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    regRdEn = 1'b1;
    @(posedge clk);
    #2;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = ~d;
    q = regRdData;
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import rxmp_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] rstVal;
    logic [7:0] mask;
  } rxmp_tb_row_t;

  logic clk, rst_b, regWrEn, regRdEn, regHit, profileActive;
  logic firstSplitterOn, pairASplitterOn, pairBSplitterOn;
  logic [RXMP_ADDR_W-1:0] regAddr;
  logic [7:0] regWrData, regRdData, d;
  logic [3:0] modeSel, chanOn;
  logic [2:0] chan1GainCode, chan2GainCode, chan3GainCode, chan4GainCode;
  logic [19:0] prof;
  int fails = 0;
  int n_checks = 0;

  // rows: address, value after reset, writable bits
  rxmp_tb_row_t rows [0:14] = '{
    '{12'h05e, 8'h7f, 8'h7f}, '{12'h05f, 8'h44, 8'h77}, '{12'h060, 8'h44, 8'h77},
    '{12'h061, 8'h68, 8'h7f}, '{12'h062, 8'h00, 8'h77}, '{12'h063, 8'h00, 8'h77},
    '{12'h064, 8'h64, 8'h7f}, '{12'h065, 8'h00, 8'h77}, '{12'h066, 8'h00, 8'h77},
    '{12'h067, 8'h52, 8'h7f}, '{12'h068, 8'h00, 8'h77}, '{12'h069, 8'h00, 8'h77},
    '{12'h06a, 8'h51, 8'h7f}, '{12'h06b, 8'h00, 8'h77}, '{12'h06c, 8'h00, 8'h77}};

  assign prof = {profileActive, firstSplitterOn, pairASplitterOn, pairBSplitterOn, chanOn,
                 chan1GainCode, chan2GainCode, chan3GainCode, chan4GainCode};

  rxmp_host_model u_host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));

  rxmp_regs u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regHit(regHit),
    .modeSel(modeSel), .profileActive(profileActive), .firstSplitterOn(firstSplitterOn),
    .pairASplitterOn(pairASplitterOn), .pairBSplitterOn(pairBSplitterOn), .chanOn(chanOn),
    .chan1GainCode(chan1GainCode), .chan2GainCode(chan2GainCode),
    .chan3GainCode(chan3GainCode), .chan4GainCode(chan4GainCode));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // channel 1 sits in the enable byte's bit 3 but chanOn bit 0
  function automatic logic [19:0] exp_prof(logic [7:0] en, logic [7:0] g12, logic [7:0] g34);
    return {1'b1, en[6:4], en[0], en[1], en[2], en[3], g12[6:4], g12[2:0], g34[6:4], g34[2:0]};
  endfunction

  // distinct pattern per row so aliased addresses show up; some reserved bits set
  function automatic logic [7:0] wr_val(int i);
    return 8'(i * 17) ^ 8'h88;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_prof(input logic [19:0] got, input logic [19:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_resets;
    logic [7:0] q;
    for (int i = 0; i < 15; i++) begin
      u_host.read_reg(rows[i].addr, q);
      chk8(q, rows[i].rstVal, "reset value");
    end
  endtask

  // profile registers on the same edge that first samples the new mode
  task automatic check_mode(input logic [3:0] m, input logic [19:0] exp);
    @(posedge clk);
    #2;
    modeSel = m;
    @(posedge clk);
    #2;
    chk_prof(prof, exp, "profile");
  endtask

  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // whole run is under two hundred cycles; this leaves wide margin
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    modeSel = 4'h0;
    repeat (5) @(posedge clk);
    #2;
    chk8(regRdData, 8'h00, "read data in reset");
    chk_prof(prof, 20'h0, "profile in reset");
    rst_b = 1'b1;
    check_resets();
    for (int m = 0; m < 5; m++) begin
      check_mode(4'ha + 4'(m), exp_prof(rows[3*m].rstVal, rows[3*m+1].rstVal,
                 rows[3*m+2].rstVal));
    end
    $display("test reset values done");
    // all writes first, then all reads, to catch address aliasing
    for (int i = 0; i < 15; i++) u_host.write_reg(rows[i].addr, wr_val(i));
    for (int i = 0; i < 15; i++) begin
      u_host.read_reg(rows[i].addr, d);
      chk8(d, wr_val(i) & rows[i].mask, "readback");
    end
    for (int m = 0; m < 5; m++) begin
      check_mode(4'ha + 4'(m), exp_prof(wr_val(3*m) & 8'h7f, wr_val(3*m+1) & 8'h77,
                 wr_val(3*m+2) & 8'h77));
    end
    $display("test write readback done");
    // unmapped neighbours on both sides of the block
    u_host.write_reg(12'h05d, 8'hff);
    u_host.write_reg(12'h06d, 8'hff);
    u_host.read_reg(12'h05d, d);
    chk8(d, 8'h00, "unmapped low read");
    chk8({7'h0, regHit}, 8'h00, "hit low");
    u_host.read_reg(12'h06d, d);
    chk8(d, 8'h00, "unmapped high read");
    u_host.read_reg(12'h06c, d);
    chk8(d, wr_val(14) & 8'h77, "last register kept");
    chk8({7'h0, regHit}, 8'h01, "hit last");
    check_mode(4'h9, 20'h0);
    check_mode(4'hf, 20'h0);
    check_mode(4'h0, 20'h0);
    $display("test unmapped done");
    u_host.write_read(12'h062, 8'h9a, d);
    chk8(d, wr_val(4) & 8'h77, "old value on same cycle");
    u_host.read_reg(12'h062, d);
    chk8(d, 8'h12, "new value after");
    // live update while the mode stays selected
    check_mode(4'hc, exp_prof(wr_val(6) & 8'h7f, wr_val(7) & 8'h77,
               wr_val(8) & 8'h77));
    u_host.write_reg(12'h064, 8'h8b);
    repeat (2) @(posedge clk);
    #2;
    chk_prof(prof, exp_prof(8'h0b, wr_val(7) & 8'h77, wr_val(8) & 8'h77), "live");
    $display("test same cycle and live update done");
    // second reset in mid-run restores every register
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    #2;
    chk_prof(prof, 20'h0, "profile in second reset");
    chk8(regRdData, 8'h00, "read data in second reset");
    rst_b = 1'b1;
    check_resets();
    $display("test second reset done");
    print_verdict();
  end
endmodule
